/* File: hw/fault_rec_consts.vh */
// constants for the hypervisor context and fault recording block
`ifndef FAULT_REC_CONSTS_VH
`define FAULT_REC_CONSTS_VH
// register byte addresses (low 8 bits of the register port address)
`define A_BANK_ATTR      8'h00
`define A_BANK_CTRL      8'h04
`define A_BANK_TCTRL     8'h08
`define A_BANK_TB0       8'h0c
`define A_BANK_TB1       8'h10
`define A_BANK_MAIR0     8'h14
`define A_BANK_MAIR1     8'h18
`define A_BANK_FSR       8'h1c
`define A_BANK_FAR       8'h20
`define A_BANK_FSYN      8'h24
`define A_BANK_RSYN      8'h28
`define A_GLB_FSR        8'h2c
`define A_GLB_FAR        8'h30
`define A_GLB_SYN0       8'h34
`define A_GLB_SYN1       8'h38
`define A_GLB_SYN2       8'h3c
`define A_IRQ_EN         8'h40
`define A_EFF_CFG        8'h44
// bank attribute fields
`define BA_HYP           8
`define BA_VIRTUAL_MACHINE_ID_HI       7
// bank control fields
`define BC_AFE           2
`define BC_TEX           1
// table control extended address bit
`define TC_EAE           31
// table base address space id field
`define TB_ADDRESS_SPACE_ID_HI       31
`define TB_ADDRESS_SPACE_ID_LO       24
// bank fault status bits
`define BF_TF            1
`define BF_PF            3
`define BF_EF            4
`define BF_MULTI         31
// global fault status bits
`define GF_ICF           0
`define GF_USF           1
`define GF_SMCF          2
`define GF_UCBF          3
`define GF_UCIF          4
`define GF_CAF           5
`define GF_PF            6
`define GF_EF            7
`define GF_MULTI         31
// fault class codes on the fault port
`define FC_W             4
`define FC_B_TRANS       4'h0
`define FC_B_PERM        4'h1
`define FC_B_EXT         4'h2
`define FC_G_INVCTX      4'h3
`define FC_G_UNID        4'h4
`define FC_G_SMCONF      4'h5
`define FC_G_UNBANK      4'h6
`define FC_G_UNIRQ       4'h7
`define FC_G_CFGACC      4'h8
`define FC_G_PERM        4'h9
`define FC_G_EXT         4'ha
// response codes toward the initiator
`define RSP_OKAY         2'h0
`define RSP_EXOKAY       2'h1
`define RSP_ERR          2'h2
`define ZERO32           32'h0000_0000
`endif

/* File: hw/hyp_fault_rec.v */
// hypervisor context bank controls and fault recording with register port
//
// Local design decisions: the address map and the plain strobed port.
`include "fault_rec_consts.vh"

// Summary of operation
// - hypervisor mode only while attribute flag set
// - hypervisor walks base 0 only, no address_space_id
// - access flag, remap, virtual_machine_id ignored in hypervisor
// - reserved descriptor bits zero, software writes
// - extended address treated as one in hypervisor
// - both attribute indirection registers used
// - bank privileged translate commands give correct results
// - global privileged translate commands correct too
// - hypervisor cache tag, no address_space_id or virtual_machine_id
// - security state not stored on hypervisor tag
// - hypervisor permissions ignore bus privilege marking
// - bank and global fault classes recognised
// - fault status captured in matching register
// - fault address captured in matching register
// - syndrome captured in matching syndrome registers
// - error response returned, downstream errors accepted
// - faulting exclusive returned as aborted
// - interrupt output may accompany recording
// - later faults only set multiple flag
// - interrupt raised when enabled status recorded
// - write one clears status bit
module hyp_fault_rec #(
  parameter AW = 32  // fault address width
) (
  input  wire          mclk_i,
  input  wire          resetn_i,
  // register port
  input  wire [7:0]    reg_addr_i,
  input  wire [31:0]   reg_wdata_i,
  input  wire          reg_wr_i,
  input  wire          reg_rd_i,
  output reg  [31:0]   reg_rdata_o,
  // translation request: effective config query
  input  wire          xlat_priv_i,      // bus privileged marking
  input  wire          xlat_cmd_user_i,  // translate command is an unprivileged variant
  // fault event port
  input  wire          fault_i,          // one-cycle fault strobe
  input  wire [3:0]    fault_class_i,
  input  wire [AW-1:0] fault_addr_i,
  input  wire [31:0]   fault_syn_i,
  input  wire [31:0]   fault_syn1_i,
  input  wire [31:0]   fault_syn2_i,
  input  wire          fault_excl_i,     // faulting transaction was exclusive
  input  wire          ds_err_i,         // downstream error on an issued transaction
  input  wire          ds_excl_i,
  input  wire [AW-1:0] ds_addr_i,
  // response and effective controls
  output reg  [1:0]    resp_o,
  output reg           resp_valid_o,
  output reg           excl_abort_o,
  output reg           irq_bank_o,
  output reg           irq_glb_o,
  output reg           hyp_o,            // bank is hypervisor context
  output reg           use_tb1_o,        // second table base in use
  output reg           long_fmt_o,       // long descriptor format in use
  output reg           afe_eff_o,
  output reg           tex_eff_o,
  output reg  [7:0]    address_space_id_eff_o,
  output reg  [7:0]    virtual_machine_id_eff_o,
  output reg           hyp_tag_o,        // allocations carry hypervisor tag
  output reg           priv_eff_o        // privilege used for permission check
);

  // configuration registers
  reg [31:0] attr_reg;    // bank attribute
  reg [31:0] ctrl_reg;    // bank control
  reg [31:0] tctrl_reg;   // bank table control
  reg [31:0] tb0_reg;     // table base 0
  reg [31:0] tb1_reg;     // table base 1
  reg [31:0] mair0_reg;   // attribute indirection 0
  reg [31:0] mair1_reg;   // attribute indirection 1
  reg [1:0]  irq_en_reg;  // bit0 bank, bit1 global
  // fault record registers
  reg [31:0] bfsr_reg;
  reg [AW-1:0] bfar_reg;
  reg [31:0] bsyn_reg;
  reg [31:0] brsyn_reg;
  reg [31:0] gfsr_reg;
  reg [AW-1:0] gfar_reg;
  reg [31:0] gsyn0_reg;
  reg [31:0] gsyn1_reg;
  reg [31:0] gsyn2_reg;

  // class decode, used for both the bank and global paths
  // bank classes are translation, permission and external; every other
  // code is a global class, and unknown codes fall on the external bit
  // so that a bad class code from a client is never silently dropped
  function is_bank_class;
    input [3:0] c;
    begin
      is_bank_class = (c == `FC_B_TRANS) || (c == `FC_B_PERM) || (c == `FC_B_EXT);
    end
  endfunction

  // status bit for a given class
  function [31:0] class_bit;
    input [3:0] c;
    begin
      class_bit = `ZERO32;
      case (c)
        `FC_B_TRANS:  class_bit[`BF_TF]   = 1'b1;
        `FC_B_PERM:   class_bit[`BF_PF]   = 1'b1;
        `FC_B_EXT:    class_bit[`BF_EF]   = 1'b1;
        `FC_G_INVCTX: class_bit[`GF_ICF]  = 1'b1;
        `FC_G_UNID:   class_bit[`GF_USF]  = 1'b1;
        `FC_G_SMCONF: class_bit[`GF_SMCF] = 1'b1;
        `FC_G_UNBANK: class_bit[`GF_UCBF] = 1'b1;
        `FC_G_UNIRQ:  class_bit[`GF_UCIF] = 1'b1;
        `FC_G_CFGACC: class_bit[`GF_CAF]  = 1'b1;
        `FC_G_PERM:   class_bit[`GF_PF]   = 1'b1;
        default:      class_bit[`GF_EF]   = 1'b1;
      endcase
    end
  endfunction

  // hypervisor mode is taken straight from the attribute flag; there is
  // no latching, so a rewrite of the flag takes effect on the next cycle
  wire hyp = attr_reg[`BA_HYP];
  // a downstream error is recorded as a bank external fault unless a client fault arrives in the same cycle
  wire        ev      = fault_i | ds_err_i;
  wire [3:0]  ev_cls  = fault_i ? fault_class_i : `FC_B_EXT;
  wire [AW-1:0] ev_addr = fault_i ? fault_addr_i : ds_addr_i;
  wire        ev_excl = fault_i ? fault_excl_i : ds_excl_i;
  wire        ev_bank = is_bank_class(ev_cls);
  wire [31:0] ev_bit  = class_bit(ev_cls);
  // pending means any indication bit still set, multi flag aside
  // a record that holds only the multi flag accepts a fresh first fault,
  // which keeps software from losing details after a partial clear
  wire        b_pend  = |(bfsr_reg & ~(32'h1 << `BF_MULTI));
  wire        g_pend  = |(gfsr_reg & ~(32'h1 << `GF_MULTI));
  wire        b_wr    = reg_wr_i && (reg_addr_i == `A_BANK_FSR);
  wire        g_wr    = reg_wr_i && (reg_addr_i == `A_GLB_FSR);

  // configuration register writes
  // writes to unmapped or record addresses are ignored here; the status
  // registers take their write-one-clear in the record processes below
  // limitation: no secure or non-secure split of the attribute register,
  // so the platform must restrict who may set the hypervisor flag
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      attr_reg   <= `ZERO32;
      ctrl_reg   <= `ZERO32;
      tctrl_reg  <= `ZERO32;
      tb0_reg    <= `ZERO32;
      tb1_reg    <= `ZERO32;
      mair0_reg  <= `ZERO32;
      mair1_reg  <= `ZERO32;
      irq_en_reg <= 2'h0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `A_BANK_ATTR) begin
        attr_reg <= reg_wdata_i;
      end else if (reg_addr_i == `A_BANK_CTRL) begin
        ctrl_reg <= reg_wdata_i;
      end else if (reg_addr_i == `A_BANK_TCTRL) begin
        tctrl_reg <= reg_wdata_i;
      end else if (reg_addr_i == `A_BANK_TB0) begin
        tb0_reg <= reg_wdata_i;
      end else if (reg_addr_i == `A_BANK_TB1) begin
        tb1_reg <= reg_wdata_i;
      end else if (reg_addr_i == `A_BANK_MAIR0) begin
        mair0_reg <= reg_wdata_i;
      end else if (reg_addr_i == `A_BANK_MAIR1) begin
        mair1_reg <= reg_wdata_i;
      end else if (reg_addr_i == `A_IRQ_EN) begin
        irq_en_reg <= reg_wdata_i[1:0];
      end
    end
  end

  // bank fault record: first fault kept, later only sets multi; set wins over clear
  // address and syndromes are loaded only for a first fault, so the
  // details software reads always belong to the bit it sees set
  // a clear landing with a new event keeps the bit that event sets
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bfsr_reg  <= `ZERO32;
      bfar_reg  <= {AW{1'b0}};
      bsyn_reg  <= `ZERO32;
      brsyn_reg <= `ZERO32;
    end else begin
      if (ev && ev_bank && b_pend) begin
        bfsr_reg <= (bfsr_reg & ~(b_wr ? reg_wdata_i : `ZERO32)) | (32'h1 << `BF_MULTI);
      end else if (ev && ev_bank) begin
        bfsr_reg  <= (bfsr_reg & ~(b_wr ? reg_wdata_i : `ZERO32)) | ev_bit;
        bfar_reg  <= ev_addr;
        bsyn_reg  <= fault_syn_i;
        brsyn_reg <= fault_syn1_i;
      end else if (b_wr) begin
        bfsr_reg <= bfsr_reg & ~reg_wdata_i;
      end
    end
  end

  // global fault record, same policy as the bank record
  // global syndromes use all three syndrome inputs; the bank record
  // keeps only two, the second one as the restricted syndrome
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gfsr_reg  <= `ZERO32;
      gfar_reg  <= {AW{1'b0}};
      gsyn0_reg <= `ZERO32;
      gsyn1_reg <= `ZERO32;
      gsyn2_reg <= `ZERO32;
    end else begin
      if (ev && !ev_bank && g_pend) begin
        gfsr_reg <= (gfsr_reg & ~(g_wr ? reg_wdata_i : `ZERO32)) | (32'h1 << `GF_MULTI);
      end else if (ev && !ev_bank) begin
        gfsr_reg  <= (gfsr_reg & ~(g_wr ? reg_wdata_i : `ZERO32)) | ev_bit;
        gfar_reg  <= ev_addr;
        gsyn0_reg <= fault_syn_i;
        gsyn1_reg <= fault_syn1_i;
        gsyn2_reg <= fault_syn2_i;
      end else if (g_wr) begin
        gfsr_reg <= gfsr_reg & ~reg_wdata_i;
      end
    end
  end

  // response toward the initiator, registered one cycle after the event
  // every encountered fault is answered, also a second one that only
  // sets multi, since the initiator must see its access fail anyway
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      resp_o       <= `RSP_OKAY;
      resp_valid_o <= 1'b0;
      excl_abort_o <= 1'b0;
    end else begin
      resp_valid_o <= ev;
      resp_o       <= ev ? `RSP_ERR : `RSP_OKAY;
      excl_abort_o <= ev && ev_excl;
    end
  end

  // interrupt levels follow pending status when enabled
  // level style: the line drops once software clears the last
  // indication bit, or masks the source in the enable register
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_bank_o <= 1'b0;
      irq_glb_o  <= 1'b0;
    end else begin
      irq_bank_o <= b_pend && irq_en_reg[0];
      irq_glb_o  <= g_pend && irq_en_reg[1];
    end
  end

  // effective translation controls; hypervisor mode overrides some fields
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hyp_o      <= 1'b0;
      use_tb1_o  <= 1'b0;
      long_fmt_o <= 1'b0;
      afe_eff_o  <= 1'b0;
      tex_eff_o  <= 1'b0;
      address_space_id_eff_o <= 8'h00;
      virtual_machine_id_eff_o <= 8'h00;
      hyp_tag_o  <= 1'b0;
      priv_eff_o <= 1'b0;
    end else begin
      hyp_o      <= hyp;
      use_tb1_o  <= !hyp;
      address_space_id_eff_o <= hyp ? 8'h00 : tb0_reg[`TB_ADDRESS_SPACE_ID_HI:`TB_ADDRESS_SPACE_ID_LO];
      afe_eff_o  <= hyp ? 1'b0 : ctrl_reg[`BC_AFE];
      tex_eff_o  <= hyp ? 1'b0 : ctrl_reg[`BC_TEX];
      virtual_machine_id_eff_o <= hyp ? 8'h00 : attr_reg[`BA_VIRTUAL_MACHINE_ID_HI:0];
      long_fmt_o <= hyp | tctrl_reg[`TC_EAE];
      // hypervisor tag carries no security state; entries are shared
      hyp_tag_o  <= hyp;
      // reserved descriptor bits of hypervisor tables are never consulted
      // here, so software writing them as zero is all that is relied on
      // hypervisor banks check as privileged whatever the bus mark; the
      // unprivileged command variants therefore check as privileged too
      priv_eff_o <= hyp ? 1'b1 : (xlat_priv_i & ~xlat_cmd_user_i);
    end
  end

  // register reads, data in the cycle after the strobe
  // read data return to zero outside the slot, which lets a wired-or
  // read bus combine several blocks without extra select logic
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= `ZERO32;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `A_BANK_ATTR) begin
        reg_rdata_o <= attr_reg;
      end else if (reg_addr_i == `A_BANK_CTRL) begin
        reg_rdata_o <= ctrl_reg;
      end else if (reg_addr_i == `A_BANK_TCTRL) begin
        reg_rdata_o <= tctrl_reg;
      end else if (reg_addr_i == `A_BANK_TB0) begin
        reg_rdata_o <= tb0_reg;
      end else if (reg_addr_i == `A_BANK_TB1) begin
        reg_rdata_o <= tb1_reg;
      end else if (reg_addr_i == `A_BANK_MAIR0) begin
        reg_rdata_o <= mair0_reg;
      end else if (reg_addr_i == `A_BANK_MAIR1) begin
        reg_rdata_o <= mair1_reg;
      end else if (reg_addr_i == `A_BANK_FSR) begin
        reg_rdata_o <= bfsr_reg;
      end else if (reg_addr_i == `A_BANK_FAR) begin
        reg_rdata_o <= bfar_reg[31:0];
      end else if (reg_addr_i == `A_BANK_FSYN) begin
        reg_rdata_o <= bsyn_reg;
      end else if (reg_addr_i == `A_BANK_RSYN) begin
        reg_rdata_o <= brsyn_reg;
      end else if (reg_addr_i == `A_GLB_FSR) begin
        reg_rdata_o <= gfsr_reg;
      end else if (reg_addr_i == `A_GLB_FAR) begin
        reg_rdata_o <= gfar_reg[31:0];
      end else if (reg_addr_i == `A_GLB_SYN0) begin
        reg_rdata_o <= gsyn0_reg;
      end else if (reg_addr_i == `A_GLB_SYN1) begin
        reg_rdata_o <= gsyn1_reg;
      end else if (reg_addr_i == `A_GLB_SYN2) begin
        reg_rdata_o <= gsyn2_reg;
      end else if (reg_addr_i == `A_IRQ_EN) begin
        reg_rdata_o <= {30'h0, irq_en_reg};
      end else if (reg_addr_i == `A_EFF_CFG) begin
        reg_rdata_o <= {28'h0, hyp_tag_o, long_fmt_o, use_tb1_o, hyp_o};
      end else begin
        reg_rdata_o <= `ZERO32; // unmapped reads as zero
      end
    end else begin
      reg_rdata_o <= `ZERO32;
    end
  end

endmodule // hyp_fault_rec

/* File: test/client_model.sv */
// client and downstream model that raises fault and error events
module client_model (
  input  wire logic        mclk_i,
  input  wire logic        go_i,
  input  wire logic [3:0]  cls_i,
  input  wire logic [31:0] adr_i,
  input  wire logic        ex_i,
  input  wire logic        ds_i,
  output wire logic        fault_o,
  output wire logic [3:0]  class_o,
  output wire logic [31:0] addr_o,
  output wire logic [31:0] syn_o,
  output wire logic [31:0] syn1_o,
  output wire logic [31:0] syn2_o,
  output wire logic        excl_o,
  output wire logic        ds_err_o,
  output wire logic        ds_excl_o,
  output wire logic [31:0] ds_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last_q = 32'h0; // last address shown on the lines
  wire  [31:0] a;              // idle lines show the inverse, never a stale copy
  // remember the address of the last event
  always @(posedge mclk_i) begin
    if (go_i) begin
      last_q <= adr_i;
    end
  end
  assign a         = go_i ? adr_i : ~last_q;
  assign fault_o   = go_i & ~ds_i;        // client side fault event
  assign ds_err_o  = go_i & ds_i;
  assign excl_o    = go_i & ex_i & ~ds_i;
  assign ds_excl_o = go_i & ex_i & ds_i;
  assign class_o   = cls_i;
  assign addr_o    = a;
  assign ds_addr_o = a;
  assign syn_o     = ~a;
  assign syn1_o    = a + 32'h1;
  assign syn2_o    = a + 32'h2;
endmodule // client_model

/* File: test/hyp_fault_rec_monitor.sv */
// assertions on the ports of the fault recorder
`include "fault_rec_consts.vh"
module hyp_fault_rec_chk (
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        fault_i,
  input wire logic        fault_excl_i,
  input wire logic        ds_err_i,
  input wire logic [1:0]  resp_o,
  input wire logic        resp_valid_o,
  input wire logic        excl_abort_o,
  input wire logic        irq_bank_o,
  input wire logic        irq_glb_o,
  input wire logic        hyp_o,
  input wire logic        use_tb1_o,
  input wire logic        long_fmt_o,
  input wire logic        afe_eff_o,
  input wire logic        tex_eff_o,
  input wire logic [7:0]  address_space_id_eff_o,
  input wire logic [7:0]  virtual_machine_id_eff_o,
  input wire logic        hyp_tag_o,
  input wire logic        priv_eff_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // every event is answered with an error next cycle
  resp_err_a:
    assert property ((fault_i || ds_err_i) |=> resp_valid_o && resp_o == `RSP_ERR) else $error("no error answer");
  // no answer without an event
  resp_src_a:
    assert property (resp_valid_o |-> $past(fault_i || ds_err_i)) else $error("spurious answer");
  excl_abort_a:
    assert property (fault_i && fault_excl_i |=> excl_abort_o) else $error("exclusive not aborted");
  rdata_idle_a:
    assert property (!reg_rd_i |=> reg_rdata_o == 32'h0) else $error("read data outside slot");
  irq_cause_a:
    assert property ($rose(irq_bank_o) || $rose(irq_glb_o) |-> $past(fault_i || ds_err_i || reg_wr_i, 2))
      else $error("interrupt without cause");
  hyp_base_a:
    assert property (hyp_o |-> !use_tb1_o && address_space_id_eff_o == 8'h00) else $error("second base or address_space_id used");
  hyp_fmt_a:
    assert property (hyp_o |-> long_fmt_o && hyp_tag_o) else $error("hyp format or tag wrong");
  hyp_ign_a:
    assert property (hyp_o |-> !afe_eff_o && !tex_eff_o && virtual_machine_id_eff_o == 8'h00) else $error("ignored field used");
  hyp_priv_a:
    assert property (hyp_o |-> priv_eff_o) else $error("hyp follows bus privilege");
  fault_irq_c: cover property (fault_i ##2 irq_bank_o);
  hyp_on_c: cover property ($rose(hyp_o));
  abort_c: cover property (excl_abort_o);
endmodule // hyp_fault_rec_chk

bind hyp_fault_rec hyp_fault_rec_chk chk (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .fault_i(fault_i), .fault_excl_i(fault_excl_i), .ds_err_i(ds_err_i), .resp_o(resp_o),
  .resp_valid_o(resp_valid_o), .excl_abort_o(excl_abort_o), .irq_bank_o(irq_bank_o), .irq_glb_o(irq_glb_o),
  .hyp_o(hyp_o), .use_tb1_o(use_tb1_o), .long_fmt_o(long_fmt_o), .afe_eff_o(afe_eff_o), .tex_eff_o(tex_eff_o),
  .address_space_id_eff_o(address_space_id_eff_o), .virtual_machine_id_eff_o(virtual_machine_id_eff_o), .hyp_tag_o(hyp_tag_o), .priv_eff_o(priv_eff_o));

/* File: test/tb_hyp_fault_rec.sv */
// self-checking bench for the fault recorder
`include "fault_rec_consts.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("mismatch %0t %h %h", $time, g, e); end end
module tb_hyp_fault_rec;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i, resetn_i, reg_wr_i, reg_rd_i, xlat_priv_i, xlat_user, m_go, m_ex, m_ds;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, rd_v, m_adr;
  logic [3:0]  m_cls;
  wire  [31:0] reg_rdata_o, f_addr, f_syn, f_syn1, f_syn2, d_addr;
  wire  [3:0]  f_cls;
  wire  [1:0]  resp_o;
  wire         f_ev, f_ex, d_err, d_ex, resp_valid_o, excl_abort_o, irq_bank_o, irq_glb_o;
  wire         hyp_o, use_tb1_o, long_fmt_o, afe_eff_o, tex_eff_o, hyp_tag_o, priv_eff_o;
  wire  [7:0]  address_space_id_eff_o, virtual_machine_id_eff_o;
  int          fail_count, tests_run, cyc;
  int          bb[3] = '{1, 3, 4}; // bank status bit of each bank class
  client_model cm (.mclk_i(mclk_i), .go_i(m_go), .cls_i(m_cls), .adr_i(m_adr), .ex_i(m_ex), .ds_i(m_ds),
    .fault_o(f_ev), .class_o(f_cls), .addr_o(f_addr), .syn_o(f_syn), .syn1_o(f_syn1), .syn2_o(f_syn2),
    .excl_o(f_ex), .ds_err_o(d_err), .ds_excl_o(d_ex), .ds_addr_o(d_addr));
  hyp_fault_rec #(.AW(32)) dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .xlat_priv_i(xlat_priv_i), .xlat_cmd_user_i(xlat_user), .fault_i(f_ev), .fault_class_i(f_cls),
    .fault_addr_i(f_addr), .fault_syn_i(f_syn), .fault_syn1_i(f_syn1), .fault_syn2_i(f_syn2),
    .fault_excl_i(f_ex), .ds_err_i(d_err), .ds_excl_i(d_ex), .ds_addr_i(d_addr), .resp_o(resp_o),
    .resp_valid_o(resp_valid_o), .excl_abort_o(excl_abort_o), .irq_bank_o(irq_bank_o), .irq_glb_o(irq_glb_o),
    .hyp_o(hyp_o), .use_tb1_o(use_tb1_o), .long_fmt_o(long_fmt_o), .afe_eff_o(afe_eff_o),
    .tex_eff_o(tex_eff_o), .address_space_id_eff_o(address_space_id_eff_o), .virtual_machine_id_eff_o(virtual_machine_id_eff_o), .hyp_tag_o(hyp_tag_o),
    .priv_eff_o(priv_eff_o));
  // one-cycle register write
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read and compare; data stands only in the cycle after the strobe
  task automatic rc(input [7:0] a, input [31:0] e);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 rd_v = reg_rdata_o;
    `CHK(rd_v, e)
  endtask
  // one event from the model; the answer pulse stands only in the cycle after the event is taken
  task automatic ev(input [3:0] c, input [31:0] a, input x, input d);
    @(posedge mclk_i);
    m_go <= 1'b1;
    m_cls <= c;
    m_adr <= a;
    m_ex <= x;
    m_ds <= d;
    @(posedge mclk_i);
    m_go <= 1'b0;
    #1;
    `CHK({resp_valid_o, resp_o}, {1'b1, `RSP_ERR})
    `CHK(excl_abort_o, x)
  endtask
  task automatic t_reset();
    rc(`A_BANK_FSR, 32'h0);
    rc(`A_GLB_FSR, 32'h0);
    wr(8'h80, 32'hffff_ffff);
    rc(8'h80, 32'h0);
  endtask
  // first fault kept, second only marks multiple, then write-one-clear
  task automatic t_record();
    wr(`A_IRQ_EN, 32'h3);
    ev(`FC_B_TRANS, 32'h1234_5678, 1'b0, 1'b0);
    rc(`A_BANK_FSR, 32'h2);
    rc(`A_BANK_FAR, 32'h1234_5678);
    rc(`A_BANK_FSYN, 32'hedcb_a987);
    rc(`A_BANK_RSYN, 32'h1234_5679);
    `CHK(irq_bank_o, 1'b1)
    ev(`FC_B_PERM, 32'h0bad_0000, 1'b1, 1'b0);
    rc(`A_BANK_FSR, 32'h8000_0002);
    rc(`A_BANK_FAR, 32'h1234_5678);
    wr(`A_BANK_FSR, 32'h2);
    rc(`A_BANK_FSR, 32'h8000_0000);
    `CHK(irq_bank_o, 1'b0)
    wr(`A_BANK_FSR, 32'h8000_0000);
    rc(`A_BANK_FSR, 32'h0);
  endtask
  // every class lands on its own status bit
  task automatic t_classes();
    for (int i = 0; i < 11; i++) begin
      ev(i[3:0], i, 1'b0, 1'b0);
      if (i < 3) begin
        rc(`A_BANK_FSR, 32'h1 << bb[i]);
        wr(`A_BANK_FSR, 32'h1 << bb[i]);
      end else begin
        rc(`A_GLB_FSR, 32'h1 << (i - 3));
        rc(`A_GLB_FAR, i);
        rc(`A_GLB_SYN0, ~i);
        rc(`A_GLB_SYN2, i + 2);
        `CHK(irq_glb_o, 1'b1)
        wr(`A_GLB_FSR, 32'h1 << (i - 3));
      end
    end
  endtask
  // downstream error on an exclusive becomes a bank external fault
  task automatic t_ds();
    ev(4'h0, 32'h00ff_0000, 1'b1, 1'b1);
    rc(`A_BANK_FSR, 32'h10);
    rc(`A_BANK_FAR, 32'h00ff_0000);
    wr(`A_BANK_FSR, 32'h10);
  endtask
  // hypervisor bank ignores its per-process controls
  task automatic t_hyp();
    xlat_priv_i <= 1'b0;
    xlat_user <= 1'b0;
    wr(`A_BANK_TB0, 32'hff00_0000);
    wr(`A_BANK_CTRL, 32'h6);
    wr(`A_BANK_ATTR, 32'h1ff);
    rc(`A_EFF_CFG, 32'hd);
    `CHK({hyp_o, priv_eff_o, address_space_id_eff_o, virtual_machine_id_eff_o, afe_eff_o}, {2'b11, 16'h0, 1'b0})
    xlat_priv_i <= 1'b1;
    xlat_user <= 1'b1;
    wr(`A_BANK_ATTR, 32'h1aa);
    rc(`A_EFF_CFG, 32'hd);
    `CHK(priv_eff_o, 1'b1)
    wr(`A_BANK_ATTR, 32'h0aa);
    rc(`A_EFF_CFG, 32'h2);
    `CHK(priv_eff_o, 1'b0)
    xlat_user <= 1'b0;
    xlat_priv_i <= 1'b0;
    rc(`A_BANK_TB1, 32'h0);
    `CHK({hyp_o, priv_eff_o, address_space_id_eff_o, virtual_machine_id_eff_o, afe_eff_o}, {2'b00, 16'hffaa, 1'b1})
    wr(`A_BANK_MAIR0, 32'h44ff_0004);
    wr(`A_BANK_MAIR1, 32'h0004_44ff);
    rc(`A_BANK_MAIR0, 32'h44ff_0004);
    rc(`A_BANK_MAIR1, 32'h0004_44ff);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  // a hang is cut off well beyond the expected run length
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    {resetn_i, reg_wr_i, reg_rd_i, xlat_priv_i, xlat_user, m_go, m_ex, m_ds} = 8'h0;
    {reg_addr_i, reg_wdata_i, m_adr, m_cls, cyc} = '0;
    repeat (3) @(posedge mclk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_record();
    t_classes();
    t_ds();
    t_hyp();
    print_verdict();
  end
endmodule // tb_hyp_fault_rec
